// File: shared/m2r_pkg.sv
// Constants and state type for the mode set two configuration bank
package m2r_pkg;
  // Byte addresses of the three registers
  localparam logic [7:0] M2R_ADDR_SYS_BUCK = 8'h2b;
  localparam logic [7:0] M2R_ADDR_RAILS = 8'h2c;
  localparam logic [7:0] M2R_ADDR_WDOG_LDO = 8'h2d;
  // Values after reset
  localparam logic [7:0] M2R_RST_SYS_BUCK = 8'h4c;
  localparam logic [7:0] M2R_RST_RAILS = 8'h4f;
  localparam logic [7:0] M2R_RST_WDOG_LDO = 8'h0c;
  // Field positions
  localparam int M2R_ON_RESP_BIT = 6;
  localparam int M2R_OFFSET_BIT = 5;
  localparam int M2R_CODE5_MSB = 4;
  localparam int M2R_AON_MSB = 7;
  localparam int M2R_AON_LSB = 4;
  localparam int M2R_WD_MSB = 7;
  localparam int M2R_WD_LSB = 6;
  // Mode set that this bank belongs to
  localparam logic [1:0] M2R_MODE_TWO = 2'h2;
  // Voltage scale in millivolts
  localparam logic [11:0] M2R_BASE_MV_15 = 12'h5dc;
  localparam logic [11:0] M2R_BASE_MV_17 = 12'h6a4;
  localparam logic [11:0] M2R_STEP_MV = 12'h019;
  localparam logic [11:0] M2R_OFFSET_MV = 12'h4b0;
  localparam logic [4:0] M2R_CODE5_MAX = 5'h18;
  localparam logic [3:0] M2R_CODE4_MAX = 4'h8;
  // Watchdog timeouts in seconds
  localparam logic [6:0] M2R_WD_S_01 = 7'h10;
  localparam logic [6:0] M2R_WD_S_10 = 7'h20;
  localparam logic [6:0] M2R_WD_S_11 = 7'h40;

  typedef struct packed {
    logic [7:0] sys_buck;
    logic [7:0] rails;
    logic [7:0] wdog_ldo;
    logic [7:0] rdata;
    logic rvalid;
    logic go_mode0;
    logic [3:0] rail_en;
    logic [11:0] buck_mv;
    logic [11:0] aon_mv;
    logic [11:0] sysldo_mv;
    logic [6:0] wd_s;
  } m2r_state_t;
endpackage

// File: verilog/m2r_mode_two_config_regs.sv
// Mode set two configuration registers and the outputs they steer
module m2r_mode_two_config_regs (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Register port behind the serial slave
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Operating mode and on-pin event
  input wire logic [1:0] MODE_SEL,
  input wire logic ON_FALL,
  output logic GO_MODE0,
  // Rail and watchdog controls
  output logic [3:0] RAIL_EN,
  output logic [11:0] SYS_BUCK_MV,
  output logic [11:0] AON_MV,
  output logic [11:0] SYS_LDO_MV,
  output logic [6:0] WDOG_TIMEOUT_S
);
  import m2r_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Five-bit code with saturation and optional offset
  function automatic logic [11:0] code5_mv(input logic [4:0] code, input logic offs);
    logic [4:0] c;
    logic [11:0] mv;
    c = (code > M2R_CODE5_MAX) ? M2R_CODE5_MAX : code;
    mv = M2R_BASE_MV_15 + 12'(c * M2R_STEP_MV);
    code5_mv = offs ? mv + M2R_OFFSET_MV : mv;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  m2r_state_t s_q;
  m2r_state_t s_d;
  logic mode2_active;
  logic [3:0] aon_c;

  assign mode2_active = (MODE_SEL == M2R_MODE_TWO);

  // Next state: register writes, read capture and derived outputs
  always_comb begin
    s_d = s_q;
    aon_c = s_q.rails[M2R_AON_MSB:M2R_AON_LSB];
    // Host writes; addresses outside the bank are ignored
    if (REG_WR) begin
      unique case (REG_ADDR)
        M2R_ADDR_SYS_BUCK: s_d.sys_buck = REG_WDATA;
        M2R_ADDR_RAILS: s_d.rails = REG_WDATA;
        M2R_ADDR_WDOG_LDO: s_d.wdog_ldo = REG_WDATA;
        default: s_d.sys_buck = s_q.sys_buck;
      endcase
    end
    // Read answers one cycle later; an unmapped address reads zero
    s_d.rvalid = REG_RD;
    if (REG_RD) begin
      unique case (REG_ADDR)
        M2R_ADDR_SYS_BUCK: s_d.rdata = s_q.sys_buck;
        M2R_ADDR_RAILS: s_d.rdata = s_q.rails;
        M2R_ADDR_WDOG_LDO: s_d.rdata = s_q.wdog_ldo;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // On-pin response only counts in mode two, which is never mode 0
    s_d.go_mode0 = ON_FALL && mode2_active
                   && !s_q.sys_buck[M2R_ON_RESP_BIT];
    // Rails and watchdog follow the stored values only in mode two
    if (mode2_active) begin
      s_d.rail_en = s_q.rails[3:0];
      s_d.buck_mv = code5_mv(s_q.sys_buck[M2R_CODE5_MSB:0], s_q.sys_buck[M2R_OFFSET_BIT]);
      s_d.sysldo_mv = code5_mv(s_q.wdog_ldo[M2R_CODE5_MSB:0], s_q.wdog_ldo[M2R_OFFSET_BIT]);
      if (aon_c > M2R_CODE4_MAX) begin
        aon_c = M2R_CODE4_MAX;
      end
      s_d.aon_mv = M2R_BASE_MV_17 + 12'(aon_c * M2R_STEP_MV);
      unique case (s_q.wdog_ldo[M2R_WD_MSB:M2R_WD_LSB])
        2'h0: s_d.wd_s = 7'h00;
        2'h1: s_d.wd_s = M2R_WD_S_01;
        2'h2: s_d.wd_s = M2R_WD_S_10;
        2'h3: s_d.wd_s = M2R_WD_S_11;
      endcase
    end else begin
      // Outside mode two another bank owns the rails, so these go quiet
      s_d.rail_en = 4'h0;
      s_d.buck_mv = 12'h000;
      s_d.aon_mv = 12'h000;
      s_d.sysldo_mv = 12'h000;
      s_d.wd_s = 7'h00;
    end
  end

  // State register
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= '{sys_buck: M2R_RST_SYS_BUCK, rails: M2R_RST_RAILS,
               wdog_ldo: M2R_RST_WDOG_LDO, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign REG_RDATA = s_q.rdata;
  assign REG_RVALID = s_q.rvalid;
  assign GO_MODE0 = s_q.go_mode0;
  assign RAIL_EN = s_q.rail_en;
  assign SYS_BUCK_MV = s_q.buck_mv;
  assign AON_MV = s_q.aon_mv;
  assign SYS_LDO_MV = s_q.sysldo_mv;
  assign WDOG_TIMEOUT_S = s_q.wd_s;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n_q);

  property p_on_return;
    (ON_FALL && mode2_active && !s_q.sys_buck[6]) |=> GO_MODE0;
  endproperty
  a_on_return: assert property (p_on_return) else $error("no return to mode 0");

  property p_on_stay;
    (ON_FALL && s_q.sys_buck[6]) |=> !GO_MODE0;
  endproperty
  a_on_stay: assert property (p_on_stay) else $error("mode change while on-pin ignored");

  // Gating on the synchronised reset keeps the release edge, where the outputs
  // still hold their reset zeros, out of the value checks
  property p_buck_offset;
    (rst_n_q && mode2_active && s_q.sys_buck == 8'h20 && !REG_WR) |=> SYS_BUCK_MV == 12'ha8c;
  endproperty
  a_buck_offset: assert property (p_buck_offset) else $error("buck offset wrong");

  property p_buck_sat;
    (rst_n_q && mode2_active && s_q.sys_buck[5:3] == 3'h3) |=> SYS_BUCK_MV == 12'h834;
  endproperty
  a_buck_sat: assert property (p_buck_sat) else $error("buck saturation wrong");

  property p_aon;
    (rst_n_q && mode2_active && s_q.rails[7:4] == 4'h4) |=> AON_MV == 12'h708;
  endproperty
  a_aon: assert property (p_aon) else $error("aon voltage wrong");

  property p_rails;
    (rst_n_q && mode2_active) |=> RAIL_EN == $past(s_q.rails[3:0]);
  endproperty
  a_rails: assert property (p_rails) else $error("rail enables wrong");

  property p_wdog;
    (rst_n_q && mode2_active && s_q.wdog_ldo[7:6] == 2'h3) |=> WDOG_TIMEOUT_S == 7'h40;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog timeout wrong");

  property p_ldo_offset;
    (rst_n_q && mode2_active && s_q.wdog_ldo[5:0] == 6'h3f) |=> SYS_LDO_MV == 12'hce4;
  endproperty
  a_ldo_offset: assert property (p_ldo_offset) else $error("ldo offset wrong");

  property p_ldo_code;
    (rst_n_q && mode2_active && s_q.wdog_ldo[5:0] == 6'h0c) |=> SYS_LDO_MV == 12'h708;
  endproperty
  a_ldo_code: assert property (p_ldo_code) else $error("ldo code wrong");

  property p_readback;
    (REG_WR && REG_ADDR == 8'h2c) ##1 (REG_RD && REG_ADDR == 8'h2c && !REG_WR)
      |=> REG_RVALID && REG_RDATA == $past(REG_WDATA, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_gate;
    !mode2_active |=> RAIL_EN == 4'h0 && WDOG_TIMEOUT_S == 7'h00 && !GO_MODE0;
  endproperty
  a_gate: assert property (p_gate) else $error("outputs live outside mode two");

  property p_unmapped_read;
    (REG_RD && REG_ADDR == 8'h2e) |=> REG_RVALID && REG_RDATA == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read wrong");

  // A stray write must not leak into any of the three registers
  property p_unmapped_write;
    (REG_WR && REG_ADDR == 8'h2e) |=> s_q.sys_buck == $past(s_q.sys_buck)
      && s_q.rails == $past(s_q.rails) && s_q.wdog_ldo == $past(s_q.wdog_ldo);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("stray write landed");

  property p_rvalid_once;
    !REG_RD |=> !REG_RVALID;
  endproperty
  a_rvalid_once: assert property (p_rvalid_once) else $error("read answer without read");

  c_return: cover property (ON_FALL && mode2_active ##1 GO_MODE0);
  c_write_read: cover property (REG_WR ##1 REG_RD ##1 REG_RVALID);
  c_wdog_on: cover property (mode2_active && WDOG_TIMEOUT_S != 7'h00);
  c_leave: cover property (mode2_active ##1 !mode2_active);
  c_unmapped: cover property (REG_RD && REG_ADDR == 8'h2e ##1 REG_RVALID);
endmodule

// File: bench/m2r_host.sv
// Host model that drives the register port behind the serial slave
module m2r_host (
  // Clock and answer
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // Requests
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Byte write; a free edge first keeps strobes from toggling twice in a step
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask
  // Write then read of one address on consecutive edges
  task automatic put_get(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
    output logic ok);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    ok = rvalid; // Answer stands one cycle after the read edge
    q = rdata;
  endtask
  // Byte read, answer awaited for a bounded number of cycles
  task automatic get(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (rvalid === 1'b1) begin
        d = rdata;
        ok = 1'b1;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask
endmodule

// File: bench/m2r_mode_two_config_regs_tb.sv
// Self-checking bench for the mode set two register bank
module m2r_mode_two_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import m2r_pkg::*;
  logic clk, rst_n, wr, rd, rvalid, on_fall, go;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] mode;
  logic [3:0] rail;
  logic [11:0] bmv, amv, lmv;
  logic [6:0] wds;
  logic [7:0] sh [3];
  logic [23:0] cor [4] = '{24'h98_80_18, 24'h39_9a_79, 24'h3f_f5_bf, 24'h20_00_e0};
  int miscompares = 0;
  int checks = 0;
  m2r_host h (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata));
  m2r_mode_two_config_regs uut (.SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .MODE_SEL(mode),
    .ON_FALL(on_fall), .GO_MODE0(go), .RAIL_EN(rail), .SYS_BUCK_MV(bmv), .AON_MV(amv),
    .SYS_LDO_MV(lmv), .WDOG_TIMEOUT_S(wds));
  // Expected millivolts; codes above the top step saturate
  function automatic logic [11:0] mv5(input logic [7:0] r);
    logic [4:0] c;
    c = (r[4:0] > 5'h18) ? 5'h18 : r[4:0];
    return 12'h5dc + 12'h019 * 12'(c) + (r[5] ? 12'h4b0 : 12'h000);
  endfunction
  function automatic logic [11:0] aon(input logic [7:0] r);
    logic [3:0] c;
    c = (r[7:4] > 4'h8) ? 4'h8 : r[7:4];
    return 12'h6a4 + 12'h019 * 12'(c);
  endfunction
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Outputs are zero whenever another mode set is active
  task automatic outs;
    logic on;
    on = (mode === 2'h2);
    chk("rail_en", 12'(rail), on ? 12'(sh[1][3:0]) : 12'h000);
    chk("buck_mv", bmv, on ? mv5(sh[0]) : 12'h000);
    chk("aon_mv", amv, on ? aon(sh[1]) : 12'h000);
    chk("ldo_mv", lmv, on ? mv5(sh[2]) : 12'h000);
    chk("wdog_s", 12'(wds), on ? 12'(sh[2][7:6] == 2'h0 ? 7'h00 : 7'h08 << sh[2][7:6]) :
      12'h000);
  endtask
  task automatic readback;
    logic [7:0] d;
    logic ok;
    for (int i = 0; i < 3; i++) begin
      h.get(8'h2b + 8'(i), d, ok);
      chk("rvalid", 12'(ok), 12'h001);
      chk("rdata", 12'(d), 12'(sh[i]));
    end
  endtask
  task automatic load(input logic [7:0] v0, input logic [7:0] v1, input logic [7:0] v2);
    h.put(8'h2b, v0);
    h.put(8'h2c, v1);
    h.put(8'h2d, v2);
    sh = '{v0, v1, v2};
    readback;
    outs;
  endtask
  // Two back-to-back on-pin events
  task automatic pulse(input logic e);
    @(posedge clk);
    #1 on_fall = 1'b1;
    repeat (2) begin
      @(posedge clk);
      #1 chk("go_mode0", 12'(go), 12'(e));
    end
    on_fall = 1'b0;
    @(posedge clk);
    #1 chk("go_mode0", 12'(go), 12'h000);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, far beyond the expected run
  initial begin
    #(40 * 3000);
    miscompares++;
    end_of_test;
  end
  initial begin
    logic [7:0] d;
    logic ok;
    void'($urandom(22021));
    rst_n = 1'b0;
    mode = 2'h2;
    on_fall = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    sh = '{8'h4c, 8'h4f, 8'h0c};
    readback;
    #1 outs;
    pulse(1'b0);
    h.get(8'h2e, d, ok);
    chk("unmapped", 12'(d), 12'h000);
    chk("unmapped_valid", 12'(ok), 12'h001);
    foreach (cor[k]) load(cor[k][23:16], cor[k][15:8], cor[k][7:0]);
    repeat (20) load(8'($urandom), 8'($urandom), 8'($urandom));
    load(8'h00, 8'h4f, 8'h0c);
    h.put_get(8'h2c, 8'ha5, d, ok);
    sh[1] = 8'ha5;
    chk("rvalid", 12'(ok), 12'h001);
    chk("rdata", 12'(d), 12'h0a5);
    h.put(8'h2e, 8'hff);
    readback;
    for (int m = 0; m < 4; m++) begin
      mode = 2'(m);
      repeat (2) @(posedge clk);
      #1 outs;
      pulse(m == 2);
    end
    end_of_test;
  end
endmodule
